// File: slu_cfg.svh
// Constants of the sensor link UART multi-octet block
//
// Function
// - Single-io mode bit set selects single-io operation, starting in driving state.
// - Driving state follows switch enables (both off if both set); UART stopped; wake-up with a switch enabled or clearing the single-io bit leaves it.
// - Wake-listen: switches off, restart timer runs, octets fill buffers 0 to 14.
// - Valid master message in wake-listen: transmit state, interrupt, timer reset.
// - Restart timer expiry in wake-listen returns to driving state.
// - After reset, or with single-io bit clear, operate in master-listen.
// - Master-listen stores octets; full message or receive error enters transmit.
// - Transmit sends host data; ends on completion or abort command.
// - Short-circuit in transmit sets short flag, returns to a listen state.
// - Data-pending flag reported on an access halts the device in WAIT.
// - In WAIT interrupt, summary and data-pending stay active; no new interrupts.
// - Register accesses keep working during WAIT.
// - Abort or send write clears interrupt, summary and data-pending quickly.
// - Command register mirrored at 0xf, followed directly by frame buffers.
// - Transmission starts once buffer zero is written; host keeps later buffers valid.
// - Interrupt asserted while fault status differs from last reported value.
// - Short-circuit handled without host action; overtemperature is only reported, in status and by interrupt.
// - Status-change interrupt dropped at the next access; host keeps final values.
// - Single-io to IO-Link is seamless; reverse during reception resets the UART.
// - Status byte returned while the address byte shifts in.
`ifndef SLU_CFG_SVH
`define SLU_CFG_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define SLU_FR_COUNT 5'h0f
`define SLU_ADDR_ALIAS 5'h0f
`define SLU_ADDR_CTRL 5'h10
`define SLU_ADDR_LINK 5'h11
`define SLU_WR_BIT 7
`define SLU_CTRL_RESET 8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SLU_CTRL_SIO 0
`define SLU_CTRL_HS 1
`define SLU_CTRL_LS 2
`define SLU_CMD_SEND 0
`define SLU_CMD_ABORT 1
`define SLU_ST_DAT 0
`define SLU_ST_INT 1
`define SLU_ST_CHK 2
`define SLU_ST_SSC 3
`define SLU_ST_UV 4
`define SLU_ST_OT 5
// ----------------------------------------
// Timing
// ----------------------------------------
`define SLU_FRAME_BITS 4'ha
`define SLU_RX_TIMEOUT_BITS 3'h4
`define SLU_TX_LEAD 4'hf
`endif

// File: slu_pkg.sv
// Types of the sensor link UART block
`default_nettype none
package slu_pkg;
	typedef enum logic [1:0] {
		SLU_SIO_DRIVE = 2'b00,
		SLU_WAKE_LISTEN = 2'b01,
		SLU_MASTER_LISTEN = 2'b10,
		SLU_TRANSMIT = 2'b11
	} slu_state_e;
	typedef logic [7:0] slu_octet_t;
endpackage
`default_nettype wire

// File: slu_stream_if.sv
// Octet stream carrier between block modules
`default_nettype none
interface slu_stream_if #(parameter int WIDTH = 8);
	logic [WIDTH-1:0] data;
	logic valid;
	logic ready;
	modport src(output data, output valid, input ready);
	modport snk(input data, input valid, output ready);
endinterface
`default_nettype wire

// File: slu_fifo.sv
// Received octet FIFO with valid and ready on both sides
`default_nettype none
module slu_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic core_clk, // Clock
	input wire logic rst, // Sync reset, high
	input wire logic flush, // Drop all entries
	slu_stream_if.snk wr_side, // Filling side
	slu_stream_if.src rd_side // Draining side
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} slu_fifo_s;
	slu_fifo_s s_r, s_nxt;
	logic push, pop;

	assign wr_side.ready = (s_r.cnt != (AW+1)'(DEPTH));
	assign rd_side.valid = (s_r.cnt != '0);
	assign rd_side.data = s_r.mem[s_r.rp];
	assign push = wr_side.valid && wr_side.ready;
	assign pop = rd_side.valid && rd_side.ready;

	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = wr_side.data;
			s_nxt.wp = s_r.wp + 1'b1;
		end
		if (pop)
			s_nxt.rp = s_r.rp + 1'b1;
		s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
		if (flush) begin
			s_nxt.wp = '0;
			s_nxt.rp = '0;
			s_nxt.cnt = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
endmodule
`default_nettype wire

// File: slu_bitdiv.sv
// Bit-rate enable divider, realigned to mid-bit on restart
`default_nettype none
module slu_bitdiv #(
	parameter int DIV = 868
) (
	input wire logic core_clk, // Clock
	input wire logic rst, // Sync reset, high
	input wire logic restart, // Realign phase to half a bit
	output logic tick // One-cycle bit enable
);
	localparam int CW = $clog2(DIV);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic tick;
	} slu_div_s;
	slu_div_s s_r, s_nxt;

	assign tick = s_r.tick;

	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (restart) begin
			s_nxt.cnt = CW'(DIV / 2);
		end else if (s_r.cnt == CW'(DIV - 1)) begin
			s_nxt.cnt = '0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
endmodule
`default_nettype wire

// File: slu_top.sv
// Multi-octet UART state machine with SPI register access
`include "slu_cfg.svh"
`default_nettype none
module slu_top #(
	parameter int BIT_CYCLES = 868,
	parameter int RESTART_CYCLES = 400000
) (
	input wire logic core_clk, // 200 MHz clock
	input wire logic rst, // Sync reset, high
	input wire logic spi_sck, // SPI clock
	input wire logic spi_ss_n, // SPI select, low
	input wire logic spi_mosi, // SPI data in
	output logic spi_miso, // SPI data out
	output logic spi_miso_oe, // MISO driven
	output logic irq, // Interrupt, level
	input wire logic line_rx, // Line data level
	input wire logic wake_req, // Master wake-up detected
	output logic line_hs_on, // High-side switch on
	output logic line_ls_on, // Low-side switch on
	input wire logic short_in, // Short-circuit status
	input wire logic undervolt_in, // Undervoltage status
	input wire logic overtemp_in // Overtemperature status
);
	localparam int RW = $clog2(RESTART_CYCLES + 1);

	typedef struct packed {
		slu_pkg::slu_state_e st;
		logic [7:0] ctrl;
		logic [14:0][7:0] fr;
		logic pend;
		logic waiting;
		logic rxerr;
		logic short_circuit_flag;
		logic [2:0] rep;
		logic sck_q;
		logic ss_q;
		logic [2:0] bitcnt;
		logic first;
		logic wr;
		logic [4:0] addr;
		logic [7:0] sh_in;
		logic [7:0] sh_out;
		logic miso_oe;
		logic rx_busy;
		logic [3:0] rx_bit;
		logic [9:0] rx_frame;
		logic [2:0] idle_bits;
		logic [3:0] rx_cnt;
		logic push;
		logic [7:0] push_data;
		logic fr0_wr;
		logic tx_arm;
		logic [3:0] tx_len;
		logic [3:0] tx_idx;
		logic tx_busy;
		logic [3:0] tx_bit;
		logic [10:0] tx_frame;
		logic [RW-1:0] restart;
		logic hs;
		logic ls;
		logic irq;
	} slu_top_s;

	slu_top_s s_r, s_nxt;
	slu_stream_if #(.WIDTH(8)) rx_in ();
	slu_stream_if #(.WIDTH(8)) rx_out ();
	logic rx_tick, tx_tick, rx_restart, tx_restart, flush;
	logic [2:0] cur_stat;

	assign rx_in.data = s_r.push_data;
	assign rx_in.valid = s_r.push;
	assign cur_stat = {overtemp_in, undervolt_in, s_r.short_circuit_flag};

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	slu_fifo #(.WIDTH(8), .DEPTH(16)) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.flush(flush),
		.wr_side(rx_in),
		.rd_side(rx_out)
	);

	slu_bitdiv #(.DIV(BIT_CYCLES)) u_rxdiv (
		.core_clk(core_clk),
		.rst(rst),
		.restart(rx_restart),
		.tick(rx_tick)
	);

	slu_bitdiv #(.DIV(BIT_CYCLES)) u_txdiv (
		.core_clk(core_clk),
		.rst(rst),
		.restart(tx_restart),
		.tick(tx_tick)
	);

	// ----------------------------------------
	// Register read view
	// ----------------------------------------
	function automatic logic [7:0] rd_reg(input slu_top_s q, input logic [4:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a < `SLU_FR_COUNT)
			v = q.fr[a[3:0]];
		else if (a == `SLU_ADDR_ALIAS || a == `SLU_ADDR_LINK)
			v = {q.rx_cnt, 1'b0, q.tx_busy, q.tx_arm, q.rxerr};
		else if (a == `SLU_ADDR_CTRL)
			v = q.ctrl;
		return v;
	endfunction

	function automatic logic [7:0] status_byte(input slu_top_s q, input logic [2:0] c);
		logic [7:0] v;
		v = 8'h00;
		v[`SLU_ST_DAT] = q.pend;
		v[`SLU_ST_INT] = q.irq;
		v[`SLU_ST_CHK] = q.rxerr;
		v[`SLU_ST_SSC] = c[0];
		v[`SLU_ST_UV] = c[1];
		v[`SLU_ST_OT] = c[2];
		return v;
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [7:0] byte_in;
		logic sck_rise, sck_fall, ss_fall, single_io_mode_bit, msg_done, rx_fail, tx_done, stop_tx;
		logic [4:0] nxt_addr;
		byte_in = 8'h00;
		nxt_addr = 5'h00;
		msg_done = 1'b0;
		rx_fail = 1'b0;
		tx_done = 1'b0;
		stop_tx = 1'b0;
		rx_restart = 1'b0;
		tx_restart = 1'b0;
		flush = 1'b0;
		s_nxt = s_r;
		s_nxt.push = 1'b0;
		s_nxt.sck_q = spi_sck;
		s_nxt.ss_q = spi_ss_n;
		sck_rise = !spi_ss_n && spi_sck && !s_r.sck_q;
		sck_fall = !spi_ss_n && !spi_sck && s_r.sck_q;
		ss_fall = s_r.ss_q && !spi_ss_n;
		single_io_mode_bit = s_r.ctrl[`SLU_CTRL_SIO];
		rx_out.ready = 1'b0;

		// SPI slave
		if (spi_ss_n) begin
			s_nxt.bitcnt = 3'h0;
			s_nxt.first = 1'b1;
			s_nxt.miso_oe = 1'b0;
		end
		if (ss_fall) begin
			s_nxt.sh_out = status_byte(s_r, cur_stat);
			s_nxt.miso_oe = 1'b1;
			s_nxt.rep = cur_stat;
			if (s_r.pend)
				s_nxt.waiting = 1'b1;
		end
		if (sck_fall && s_r.bitcnt != 3'h0)
			s_nxt.sh_out = {s_r.sh_out[6:0], 1'b0};
		if (sck_rise) begin
			byte_in = {s_r.sh_in[6:0], spi_mosi};
			s_nxt.sh_in = byte_in;
			s_nxt.bitcnt = s_r.bitcnt + 3'h1;
			if (s_r.bitcnt == 3'h7) begin
				if (s_r.first) begin
					s_nxt.first = 1'b0;
					s_nxt.addr = byte_in[4:0];
					s_nxt.wr = byte_in[`SLU_WR_BIT];
					s_nxt.sh_out = rd_reg(s_r, byte_in[4:0]);
				end else begin
					nxt_addr = (s_r.addr == `SLU_ADDR_ALIAS) ? 5'h00 : s_r.addr + 5'h01;
					s_nxt.addr = nxt_addr;
					s_nxt.sh_out = rd_reg(s_r, nxt_addr);
					if (s_r.wr) begin
						if (s_r.addr < `SLU_FR_COUNT) begin
							s_nxt.fr[s_r.addr[3:0]] = byte_in;
							if (s_r.addr == 5'h00)
								s_nxt.fr0_wr = 1'b1;
						end else if (s_r.addr == `SLU_ADDR_CTRL) begin
							s_nxt.ctrl = byte_in;
						end else if (s_r.addr == `SLU_ADDR_ALIAS || s_r.addr == `SLU_ADDR_LINK) begin
							if (byte_in[`SLU_CMD_SEND] || byte_in[`SLU_CMD_ABORT]) begin
								s_nxt.pend = 1'b0;
								s_nxt.waiting = 1'b0;
							end
							if (byte_in[`SLU_CMD_SEND] && s_r.st == slu_pkg::SLU_TRANSMIT) begin
								s_nxt.tx_arm = 1'b1;
								s_nxt.tx_len = byte_in[7:4];
							end
							if (byte_in[`SLU_CMD_ABORT])
								stop_tx = 1'b1;
						end
					end
				end
			end
		end

		// Line receiver: start, 8 data, even parity, stop
		if (!s_r.rx_busy) begin
			if (!line_rx && (s_r.st == slu_pkg::SLU_MASTER_LISTEN
				|| s_r.st == slu_pkg::SLU_WAKE_LISTEN)) begin
				s_nxt.rx_busy = 1'b1;
				s_nxt.rx_bit = 4'h0;
				s_nxt.idle_bits = 3'h0;
				rx_restart = 1'b1;
			end else if (rx_tick && s_r.rx_cnt != 4'h0 && s_r.idle_bits != `SLU_RX_TIMEOUT_BITS) begin
				s_nxt.idle_bits = s_r.idle_bits + 3'h1;
			end
		end else if (rx_tick) begin
			s_nxt.rx_frame = {line_rx, s_r.rx_frame[9:1]};
			s_nxt.rx_bit = s_r.rx_bit + 4'h1;
			if (s_r.rx_bit == `SLU_FRAME_BITS) begin
				s_nxt.rx_busy = 1'b0;
				if (line_rx && s_r.rx_frame[0] == 1'b0 && ^s_r.rx_frame[9:1] == 1'b0) begin
					s_nxt.push = 1'b1;
					s_nxt.push_data = s_r.rx_frame[8:1];
					if (!rx_in.ready)
						rx_fail = 1'b1;
				end else begin
					rx_fail = 1'b1;
				end
			end
		end

		// Drain received octets into the frame buffers
		if ((s_r.st == slu_pkg::SLU_MASTER_LISTEN || s_r.st == slu_pkg::SLU_WAKE_LISTEN)
			&& s_r.rx_cnt < 4'(`SLU_FR_COUNT)) begin
			rx_out.ready = 1'b1;
			if (rx_out.valid) begin
				s_nxt.fr[s_r.rx_cnt] = rx_out.data;
				s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
			end
		end
		msg_done = s_r.rx_cnt != 4'h0 && s_r.rx_cnt == s_r.ctrl[7:4];
		if (s_r.idle_bits == `SLU_RX_TIMEOUT_BITS && !msg_done)
			rx_fail = 1'b1;

		// Line transmitter
		if (!s_r.tx_busy) begin
			if (s_r.tx_arm && s_r.fr0_wr) begin
				s_nxt.tx_busy = 1'b1;
				s_nxt.tx_bit = `SLU_TX_LEAD; // Half-bit lead-in keeps start bit full
				s_nxt.tx_frame = {1'b1, ^s_r.fr[s_r.tx_idx], s_r.fr[s_r.tx_idx], 1'b0};
				tx_restart = 1'b1;
			end
		end else if (tx_tick) begin
			s_nxt.tx_frame = (s_r.tx_bit == `SLU_TX_LEAD) ? s_r.tx_frame : {1'b1, s_r.tx_frame[10:1]};
			s_nxt.tx_bit = s_r.tx_bit + 4'h1;
			if (s_r.tx_bit == `SLU_FRAME_BITS) begin
				s_nxt.tx_busy = 1'b0;
				s_nxt.tx_idx = s_r.tx_idx + 4'h1;
				if (s_r.tx_idx + 4'h1 >= s_r.tx_len)
					tx_done = 1'b1;
			end
		end

		// Operating state
		unique case (s_r.st)
			slu_pkg::SLU_SIO_DRIVE: begin
				s_nxt.hs = s_r.ctrl[`SLU_CTRL_HS] && !s_r.ctrl[`SLU_CTRL_LS];
				s_nxt.ls = s_r.ctrl[`SLU_CTRL_LS] && !s_r.ctrl[`SLU_CTRL_HS];
				s_nxt.rx_cnt = 4'h0;
				if (!single_io_mode_bit) begin
					s_nxt.st = slu_pkg::SLU_MASTER_LISTEN;
				end else if (wake_req && (s_r.ctrl[`SLU_CTRL_HS] || s_r.ctrl[`SLU_CTRL_LS])) begin
					s_nxt.st = slu_pkg::SLU_WAKE_LISTEN;
					s_nxt.restart = RW'(RESTART_CYCLES);
					flush = 1'b1;
				end
			end
			slu_pkg::SLU_WAKE_LISTEN: begin
				s_nxt.hs = 1'b0;
				s_nxt.ls = 1'b0;
				if (s_r.restart != '0)
					s_nxt.restart = s_r.restart - 1'b1;
				if (msg_done && !s_r.waiting) begin
					s_nxt.st = slu_pkg::SLU_TRANSMIT;
					s_nxt.pend = 1'b1;
					s_nxt.restart = '0;
				end else if (!single_io_mode_bit) begin
					s_nxt.st = slu_pkg::SLU_MASTER_LISTEN;
				end else if (s_r.restart == RW'(1)) begin
					s_nxt.st = slu_pkg::SLU_SIO_DRIVE;
				end else if (rx_fail) begin
					s_nxt.rx_cnt = 4'h0;
					s_nxt.idle_bits = 3'h0;
				end
			end
			slu_pkg::SLU_MASTER_LISTEN: begin
				s_nxt.hs = 1'b0;
				s_nxt.ls = 1'b0;
				if (single_io_mode_bit) begin
					s_nxt.st = slu_pkg::SLU_SIO_DRIVE;
					s_nxt.rx_busy = 1'b0;
					s_nxt.rx_cnt = 4'h0;
					flush = 1'b1;
				end else if ((msg_done || rx_fail) && !s_r.waiting) begin
					s_nxt.st = slu_pkg::SLU_TRANSMIT;
					s_nxt.pend = 1'b1;
					s_nxt.rxerr = rx_fail && !msg_done;
				end
			end
			slu_pkg::SLU_TRANSMIT: begin
				s_nxt.hs = s_r.tx_busy && s_r.tx_bit != `SLU_TX_LEAD && s_r.tx_frame[0];
				s_nxt.ls = s_r.tx_busy && s_r.tx_bit != `SLU_TX_LEAD && !s_r.tx_frame[0];
				if (short_in) begin
					s_nxt.st = single_io_mode_bit ? slu_pkg::SLU_WAKE_LISTEN
						: slu_pkg::SLU_MASTER_LISTEN;
					s_nxt.restart = RW'(RESTART_CYCLES);
					stop_tx = 1'b1;
				end else if (tx_done || stop_tx) begin
					s_nxt.st = single_io_mode_bit ? slu_pkg::SLU_SIO_DRIVE
						: slu_pkg::SLU_MASTER_LISTEN;
				end
			end
		endcase

		// Leaving transmit clears message and transmit context
		if (s_r.st == slu_pkg::SLU_TRANSMIT && s_nxt.st != slu_pkg::SLU_TRANSMIT) begin
			stop_tx = 1'b1;
			s_nxt.rx_cnt = 4'h0;
			s_nxt.rxerr = 1'b0;
			s_nxt.idle_bits = 3'h0;
			flush = 1'b1;
		end
		if (s_r.st != slu_pkg::SLU_TRANSMIT && s_nxt.st == slu_pkg::SLU_TRANSMIT)
			s_nxt.fr0_wr = 1'b0;
		if (stop_tx) begin
			s_nxt.tx_arm = 1'b0;
			s_nxt.tx_busy = 1'b0;
			s_nxt.tx_idx = 4'h0;
			s_nxt.hs = 1'b0;
			s_nxt.ls = 1'b0;
		end

		// Short flag: set by the fault, cleared once reported with the fault gone
		if (ss_fall && !short_in)
			s_nxt.short_circuit_flag = 1'b0;
		if (short_in)
			s_nxt.short_circuit_flag = 1'b1;

		s_nxt.irq = s_nxt.pend || s_nxt.waiting
			|| ({overtemp_in, undervolt_in, s_nxt.short_circuit_flag} != s_nxt.rep);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_r <= '0;
			s_r.st <= slu_pkg::SLU_MASTER_LISTEN;
			s_r.ctrl <= `SLU_CTRL_RESET;
			s_r.ss_q <= 1'b1;
			s_r.first <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign spi_miso = s_r.sh_out[7];
	assign spi_miso_oe = s_r.miso_oe;
	assign irq = s_r.irq;
	assign line_hs_on = s_r.hs;
	assign line_ls_on = s_r.ls;
endmodule
`default_nettype wire

// File: slu_monitor.sv
// Assertion checker for the multi-octet UART block
`default_nettype none
module slu_monitor #(
	parameter int BIT_CYCLES = 868,
	parameter int RESTART_CYCLES = 400000
) (
	input wire logic core_clk, // Clock
	input wire logic rst, // Sync reset
	input wire logic spi_sck, // SPI clock
	input wire logic spi_ss_n, // SPI select
	input wire logic spi_mosi, // SPI data in
	input wire logic spi_miso, // SPI data out
	input wire logic spi_miso_oe, // MISO driven
	input wire logic irq, // Interrupt
	input wire logic line_rx, // Line level
	input wire logic wake_req, // Wake-up
	input wire logic line_hs_on, // High side
	input wire logic line_ls_on, // Low side
	input wire logic short_in, // Short status
	input wire logic undervolt_in, // Undervoltage status
	input wire logic overtemp_in // Overtemperature status
);
	// ----------------------------------------
	// Cycles since last access or fault change
	// ----------------------------------------
	logic [3:0] quiet_r;
	logic [3:0] quiet_nxt;
	logic [2:0] flt_r;
	always_comb begin
		quiet_nxt = (quiet_r == 4'hf) ? quiet_r : quiet_r + 4'h1;
		if (!spi_ss_n || {short_in, undervolt_in, overtemp_in} != flt_r)
			quiet_nxt = 4'h0;
	end
	always_ff @(posedge core_clk) begin
		quiet_r <= rst ? 4'h0 : quiet_nxt;
		flt_r <= {short_in, undervolt_in, overtemp_in};
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge core_clk); endclocking
	sequence sel_start;
		$fell(spi_ss_n);
	endsequence
	sequence sck_high_run;
		(!spi_ss_n && spi_sck)[*3];
	endsequence
	sequence fault_rise(sig);
		$rose(sig) && spi_ss_n ##1 (sig && spi_ss_n)[*3];
	endsequence
	chk_reset_outputs_off: assert property (disable iff (rst) $fell(rst) |->
		!irq && !line_hs_on && !line_ls_on && !spi_miso_oe) else $error("outputs on after reset");
	chk_first_status_bit: assert property (disable iff (rst) sel_start |=>
		spi_miso_oe && !spi_miso) else $error("status msb wrong at select");
	chk_oe_follows_sel: assert property (disable iff (rst) !spi_ss_n ##1 !spi_ss_n |->
		spi_miso_oe) else $error("miso not driven while selected");
	chk_oe_released: assert property (disable iff (rst) spi_ss_n ##1 spi_ss_n |->
		!spi_miso_oe) else $error("miso driven while deselected");
	chk_miso_holds: assert property (disable iff (rst) sck_high_run |->
		$stable(spi_miso)) else $error("miso moved while sck high");
	chk_switch_excl: assert property (disable iff (rst) !(line_hs_on && line_ls_on))
		else $error("both switches on");
	chk_ot_irq_set: assert property (disable iff (rst) fault_rise(overtemp_in) |-> irq)
		else $error("no interrupt on overtemperature");
	chk_short_irq_set: assert property (disable iff (rst) fault_rise(short_in) |-> irq)
		else $error("no interrupt on short");
	chk_uv_irq_set: assert property (disable iff (rst) fault_rise(undervolt_in) |-> irq)
		else $error("no interrupt on undervoltage");
	chk_irq_held: assert property (disable iff (rst) $fell(irq) |-> quiet_r < 4'h6)
		else $error("interrupt dropped without cause");
endmodule
bind slu_top slu_monitor #(.BIT_CYCLES(BIT_CYCLES), .RESTART_CYCLES(RESTART_CYCLES)) u_mon (
	.core_clk(core_clk), .rst(rst), .spi_sck(spi_sck), .spi_ss_n(spi_ss_n),
	.spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .irq(irq),
	.line_rx(line_rx), .wake_req(wake_req), .line_hs_on(line_hs_on),
	.line_ls_on(line_ls_on), .short_in(short_in), .undervolt_in(undervolt_in),
	.overtemp_in(overtemp_in));
`default_nettype wire

// File: slu_master_model.sv
// Line master model: sends frames, wakes the device, receives replies
`default_nettype none
module slu_master_model #(
	parameter int BIT_CYCLES = 868
) (
	input wire logic core_clk, // Clock
	input wire logic line_hs_on, // Device high side
	input wire logic line_ls_on, // Device low side
	output logic line_rx, // Line level
	output logic wake_req // Wake-up seen
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		line_rx = 1'b1;
		wake_req = 1'b0;
	end
	task automatic bit_wait(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wake_pulse();
		wake_req = 1'b1;
		bit_wait(4);
		wake_req = 1'b0;
	endtask
	// Start, data LSB first, even parity, stop
	task automatic send_octet(input logic [7:0] d, input logic bad_par);
		logic [10:0] f;
		f = {1'b1, ^d ^ bad_par, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			line_rx = f[i];
			bit_wait(BIT_CYCLES);
		end
	endtask
	task automatic recv_octet(output logic [7:0] d, output logic ok);
		int n;
		n = 0;
		d = 8'h00;
		while (line_ls_on !== 1'b1 && n < 4000) begin
			bit_wait(1);
			n++;
		end
		bit_wait(BIT_CYCLES / 2);
		for (int i = 0; i < 8; i++) begin
			bit_wait(BIT_CYCLES);
			d[i] = line_hs_on;
		end
		bit_wait(BIT_CYCLES);
		ok = (line_hs_on === ^d) && (n < 4000);
		bit_wait(BIT_CYCLES);
		ok = ok && line_hs_on;
	endtask
endmodule
`default_nettype wire

// File: slu_top_tb.sv
// Testbench for the multi-octet UART block
`default_nettype none
module slu_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, rst, spi_sck, spi_ss_n, spi_mosi, spi_miso, spi_miso_oe, irq;
	logic line_rx, wake_req, line_hs_on, line_ls_on, short_in, undervolt_in, overtemp_in;
	logic [7:0] wbuf [0:3];
	logic [7:0] rbuf [0:4];
	logic [7:0] rx;
	logic ok;
	int fail_count = 0;
	int check_count = 0;
	wire logic [7:0] sw = {6'h0, line_hs_on, line_ls_on};
	slu_top #(.BIT_CYCLES(16), .RESTART_CYCLES(1000)) dut (.core_clk(core_clk), .rst(rst),
		.spi_sck(spi_sck), .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.spi_miso_oe(spi_miso_oe), .irq(irq), .line_rx(line_rx), .wake_req(wake_req),
		.line_hs_on(line_hs_on), .line_ls_on(line_ls_on), .short_in(short_in),
		.undervolt_in(undervolt_in), .overtemp_in(overtemp_in));
	slu_master_model #(.BIT_CYCLES(16)) mst (.core_clk(core_clk), .line_hs_on(line_hs_on),
		.line_ls_on(line_ls_on), .line_rx(line_rx), .wake_req(wake_req));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// ----------------------------------------
	// Access and checking tasks
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic sbyte(input logic [7:0] tx, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			spi_sck = 1'b0;
			spi_mosi = tx[i];
			cyc(3);
			r[i] = spi_miso;
			spi_sck = 1'b1;
			cyc(3);
		end
	endtask
	task automatic acc(input logic [7:0] a, input int n);
		spi_ss_n = 1'b0;
		cyc(2);
		sbyte(a, rbuf[0]);
		for (int k = 0; k < n; k++)
			sbyte(wbuf[k], rbuf[k + 1]);
		spi_sck = 1'b0;
		cyc(3);
		spi_ss_n = 1'b1;
		cyc(3);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wbuf[0] = d;
		acc(8'h80 | a, 1);
	endtask
	task automatic rd(input logic [7:0] a);
		wbuf[0] = 8'h00;
		acc(a, 1);
	endtask
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 2000) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		cyc(40000);
		fail_count++;
		end_sim();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{rst, spi_sck, spi_ss_n, spi_mosi} = 4'b1010;
		{short_in, undervolt_in, overtemp_in} = 3'b000;
		cyc(3);
		rst = 1'b0;
		cyc(1);
		rd(8'h10);
		check("status", rbuf[0], 8'h00);
		check("ctrl", rbuf[1], 8'h00);
		check("switches", sw, 8'h00);
		wbuf[0] = 8'h33;
		acc(8'h10, 1);
		wr(8'h12, 8'h5a);
		rd(8'h10);
		check("ctrl_ro", rbuf[1], 8'h00);
		rd(8'h12);
		check("unmapped", rbuf[1], 8'h00);
		$display("test reset done");
		wr(8'h10, 8'h20);
		mst.send_octet(8'h3c, 1'b0);
		mst.send_octet(8'h81, 1'b0);
		wait_irq();
		check("irq_msg", {7'h0, irq}, 8'h01);
		acc(8'h0f, 3);
		check("data_pending_flag", rbuf[0], 8'h03);
		check("alias", rbuf[1], 8'h20);
		check("fr0", rbuf[2], 8'h3c);
		check("fr1", rbuf[3], 8'h81);
		check("irq_wait", {7'h0, irq}, 8'h01);
		wr(8'h01, 8'h77);
		rd(8'h01);
		check("status_wait", rbuf[0], 8'h03);
		check("fr1_wr", rbuf[1], 8'h77);
		wbuf[0] = 8'h11;
		wbuf[1] = 8'ha5;
		fork
			mst.recv_octet(rx, ok);
			begin
				acc(8'h8f, 2);
				check("irq_send", {7'h0, irq}, 8'h00);
			end
		join
		check("tx", rx, 8'ha5);
		check("tx_ok", {7'h0, ok}, 8'h01);
		rd(8'h10);
		check("status_idle", rbuf[0], 8'h00);
		$display("test message done");
		mst.send_octet(8'h10, 1'b1);
		wait_irq();
		rd(8'h11);
		check("status_err", rbuf[0], 8'h07);
		wr(8'h11, 8'h02);
		check("irq_abort", {7'h0, irq}, 8'h00);
		cyc(40);
		check("no_tx", sw, 8'h00);
		$display("test abort done");
		for (int i = 0; i < 3; i++) begin
			{short_in, undervolt_in, overtemp_in} = 3'b100 >> i;
			cyc(6);
			check("irq_fault", {7'h0, irq}, 8'h01);
			rd(8'h10);
			check("fault_bit", {7'h0, rbuf[0][3 + i]}, 8'h01);
			check("irq_drop", {7'h0, irq}, 8'h00);
			{short_in, undervolt_in, overtemp_in} = 3'b000;
			cyc(6);
			rd(8'h10);
			rd(8'h10);
			check("irq_idle", {7'h0, irq}, 8'h00);
		end
		$display("test faults done");
		for (int i = 0; i < 3; i++) begin
			wr(8'h10, 8'h23 + 8'(2 * i));
			cyc(2);
			check("sio_drive", sw, 8'h02 >> i);
		end
		wr(8'h10, 8'h23);
		mst.wake_pulse();
		cyc(4);
		check("wake_off", sw, 8'h00);
		cyc(900);
		check("timer_run", sw, 8'h00);
		cyc(120);
		check("restart", sw, 8'h02);
		mst.wake_pulse();
		mst.send_octet(8'h5e, 1'b0);
		mst.send_octet(8'h0f, 1'b0);
		wait_irq();
		check("irq_wake", {7'h0, irq}, 8'h01);
		rd(8'h00);
		check("wake_fr0", rbuf[1], 8'h5e);
		wr(8'h11, 8'h02);
		cyc(4);
		check("sio_back", sw, 8'h02);
		wr(8'h10, 8'h20);
		cyc(2);
		check("io_link", sw, 8'h00);
		$display("test single io done");
		end_sim();
	end
endmodule
`default_nettype wire
